// file: flash_dev_model.sv
// Flash device model: command latch, page register, busy timing, status and ID
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int BUSY = 150,
  parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVICE = 8'ha5 // Arbitrary value
) (
  input wire clk,
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire output_strobe_n,
  input wire wp_n,
  input wire [7:0] io_out,
  input wire io_oe_n,
  input wire fail_next,
  output wire [7:0] io_in,
  output wire ready_busy
);
  logic [7:0] pg [0:527];
  logic [7:0] cmd = 8'h00, dout = 8'hff, last = 8'h00;
  int col = 0, acnt = 0, idn = 0, busy = 0, base = 0;
  bit loaded = 0, erasing = 0, susp = 0, fail = 0;
  wire [7:0] stat = {wp_n, busy == 0, susp, 4'h0, fail};
  // Open-drain with pull-up: high whenever the device lets go
  assign ready_busy = (busy == 0);
  // Status follows live state while selected; a released bus never shows a stale byte
  assign io_in = (!ce_n && !output_strobe_n) ? (cmd == 8'h70 ? stat : dout) : ~last;
  initial foreach (pg[i]) pg[i] = 8'hff;
  // Busy countdown; the finishing operation latches its result
  always @(posedge clk)
    if (busy > 0) begin
      if (busy == 1) begin
        fail = fail_next;
        if (!susp) erasing = 0;
      end
      busy = busy - 1;
    end
  // Each falling read strobe presents the next byte
  always @(negedge output_strobe_n)
    if (!ce_n) begin
      dout = (cmd == 8'h90) ? (idn == 0 ? MAKER : DEVICE) : pg[col % 528];
      idn++;
      col++;
    end
  always @(posedge output_strobe_n)
    last = (cmd == 8'h70) ? stat : dout;
  // Command, address and data bytes latch on the rising write strobe
  always @(posedge we_n)
    if (!ce_n && !io_oe_n) begin
      if (cle) begin
        acnt = 0;
        if (busy == 0 || io_out == 8'h70 || io_out == 8'hb0 || io_out == 8'hff)
          case (io_out)
            8'h10: if (loaded) begin
              busy = BUSY;
              loaded = 0;
              fail = 0;
              if (base == 256) base = 0;
            end
            8'hd0: if (susp || cmd == 8'h60) begin
              susp = 0;
              erasing = 1;
              busy = BUSY;
              fail = 0;
              if (base == 256) base = 0;
            end
            8'hb0: if (erasing && busy > 0) begin
              susp = 1;
              busy = 0;
            end
            8'hff: if (!(cmd == 8'hff && busy > 0)) begin
              busy = BUSY / 4;
              susp = 0;
              erasing = 0;
              col = 0;
              base = 0;
              cmd = io_out;
              foreach (pg[i]) pg[i] = 8'hff;
            end
            // Read commands return cmd to 00h, drop any loaded data and move the pointer; a second-half pointer lasts until the next program or erase confirm or reset
            8'h00, 8'h01, 8'h50: begin
              cmd = 8'h00;
              idn = 0;
              loaded = 0;
              base = (io_out == 8'h01) ? 256 : (io_out == 8'h50) ? 512 : 0;
            end
            default: begin
              cmd = io_out;
              idn = 0;
              loaded = 0;
            end
          endcase
      end else if (ale) begin
        if (cmd != 8'h60 && acnt == 0)
          col = (base == 512) ? base + io_out[3:0] : base + io_out;
        acnt++;
        if (cmd == 8'h00 && acnt == 3) busy = BUSY / 2;
      end else if (cmd == 8'h80) begin
        pg[col % 528] = io_out;
        col++;
        loaded = 1;
      end
    end
endmodule

// file: nand_host_ctrl.v
// NAND flash host controller: Avalon-MM registers, command sequencer, pin driver
`timescale 1ns/1ps
`include "nand_host_defines.vh"
module nand_host_ctrl (
  input wire clk,
  input wire rst,
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  output reg ce_n,
  output reg cle,
  output reg ale,
  output reg we_n,
  output reg output_strobe_n,
  output reg wp_n,
  output reg [7:0] io_out,
  output reg io_oe_n,
  input wire [7:0] io_in,
  input wire ready_busy_in
);
  localparam S_IDLE = 4'h0;
  localparam S_CMD1 = 4'h1;
  localparam S_ADDR = 4'h2;
  localparam S_WDATA = 4'h3;
  localparam S_CMD2 = 4'h4;
  localparam S_WAIT = 4'h5;
  localparam S_SCMD = 4'h6;
  localparam S_RDATA = 4'h7;
  localparam S_END = 4'h8;

  reg [3:0] op;
  reg no_wait;
  reg [1:0] area;
  reg [21:0] addr;
  reg [9:0] len;
  reg [9:0] ptr;
  reg [7:0] status_byte;
  reg [7:0] maker_id;
  reg [7:0] dev_id;
  reg refused;
  reg suspended;
  reg [8:0] susp_blk;
  reg [12:0] last_page;
  reg [3:0] part_cnt;
  reg [3:0] state;
  reg [3:0] ph;
  reg [9:0] cnt;
  reg stat_rd;
  reg [1:0] bus_cnt;
  wire [8:0] sync_q;
  wire [7:0] mem_q;

  // Number of address bytes each operation sends
  function [1:0] n_addr;
    input [3:0] o;
    begin
      case (o)
        `OP_READ: n_addr = 2'd3;
        `OP_PROG: n_addr = 2'd3;
        `OP_ERASE: n_addr = 2'd2;
        `OP_ID: n_addr = 2'd1;
        default: n_addr = 2'd0;
      endcase
    end
  endfunction

  // First command byte; the pointer command is resent each time
  function [7:0] first_cmd;
    input [3:0] o;
    input [1:0] a;
    begin
      case (o)
        `OP_READ: first_cmd = (a == 2'd1) ? `CMD_READ_B :
                              (a == 2'd2) ? `CMD_READ_C : `CMD_READ_A;
        `OP_PROG: first_cmd = `CMD_LOAD;
        `OP_ERASE: first_cmd = `CMD_ERASE;
        `OP_SUSP: first_cmd = `CMD_SUSP;
        `OP_RESUME: first_cmd = `CMD_CONFIRM;
        `OP_STATUS: first_cmd = `CMD_STATUS;
        `OP_ID: first_cmd = `CMD_ID;
        default: first_cmd = `CMD_RESET;
      endcase
    end
  endfunction

  // Address byte by position; erase skips the column byte
  function [7:0] addr_byte;
    input [21:0] a;
    input [3:0] o;
    input [1:0] idx;
    reg [1:0] k;
    begin
      k = (o == `OP_ERASE) ? idx + 2'd1 : idx;
      case (k)
        2'd0: addr_byte = (o == `OP_ID) ? 8'h00 : a[7:0];
        2'd1: addr_byte = a[16:9];
        default: addr_byte = {3'h0, a[21:17]};
      endcase
    end
  endfunction

  pin_sync u_sync (
    .clk(clk),
    .rst(rst),
    .d({ready_busy_in, io_in}),
    .q(sync_q)
  );
  wire [7:0] io_s = sync_q[7:0];
  wire rb_s = sync_q[8];

  // Bus handshake: the transfer is taken where waitrequest is low
  wire do_wr = write && !waitrequest;
  wire do_rd = read && !waitrequest;
  wire op_busy = (state != S_IDLE);
  wire ctrl_wr = do_wr && (address[4:2] == `REG_CTRL);
  wire [3:0] new_op = writedata[3:0];
  wire blk_hit = suspended && (addr[21:13] == susp_blk);
  wire page_full = (addr[21:9] == last_page) && (part_cnt == `MAX_PARTIAL);
  // Device busy: only status, reset and suspend may go out
  wire dev_ok = rb_s || new_op == `OP_STATUS || new_op == `OP_RESET ||
                new_op == `OP_SUSP;
  wire refuse = !dev_ok ||
                (new_op == `OP_PROG && (len == 10'h000 || page_full || blk_hit)) ||
                (new_op == `OP_READ && blk_hit) || (new_op == `OP_ERASE && suspended);
  wire go_req = ctrl_wr && !op_busy && new_op != `OP_NONE && new_op <= `OP_RESET;
  wire start = go_req && !refuse;

  // Byte phase decode for the write and read strobe cycles
  wire wr_state = state == S_CMD1 || state == S_ADDR || state == S_WDATA ||
                  state == S_CMD2 || state == S_SCMD;
  wire wr_last = wr_state && ph == `WR_LAST;
  wire rd_last = state == S_RDATA && ph == `RD_LAST;
  wire cap = state == S_RDATA && ph == `RD_SAMPLE;
  wire [9:0] nread = stat_rd ? 10'h001 : (op == `OP_READ) ? len :
                     (op == `OP_ID) ? 10'h002 : 10'h001;
  reg [7:0] wbyte;
  always @* begin
    case (state)
      S_CMD1: wbyte = first_cmd(op, area);
      S_ADDR: wbyte = addr_byte(addr, op, cnt[1:0]);
      S_WDATA: wbyte = mem_q;
      S_CMD2: wbyte = (op == `OP_PROG) ? `CMD_PROG : `CMD_CONFIRM;
      default: wbyte = `CMD_STATUS;
    endcase
  end

  // Buffer port goes to the sequencer while an operation runs
  wire host_buf = !op_busy && (address[4:2] == `REG_DATA);
  wire buf_we = (cap && op == `OP_READ && !stat_rd) || (do_wr && host_buf);
  page_buf u_buf (
    .clk(clk),
    .addr(op_busy ? cnt : ptr),
    .we(buf_we),
    .wdata(op_busy ? io_s : writedata[7:0]),
    .rdata(mem_q)
  );

  // Read mux for the register file
  reg [31:0] rd_val;
  always @* begin
    case (address[4:2])
      `REG_CTRL: rd_val = {23'h0, wp_n, 1'b0, area, no_wait, op};
      `REG_ADDR: rd_val = {10'h0, addr};
      `REG_LEN: rd_val = {22'h0, len};
      `REG_STAT: rd_val = {16'h0, part_cnt, rb_s, suspended, refused, op_busy, status_byte};
      `REG_ID: rd_val = {16'h0, dev_id, maker_id};
      `REG_PTR: rd_val = {22'h0, ptr};
      `REG_DATA: rd_val = {24'h0, mem_q};
      default: rd_val = 32'h0;
    endcase
  end

  // Waitrequest drops two edges after a request; gives the buffer time to read
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      bus_cnt <= 2'h0;
      readdata <= 32'h0;
    end else if ((read || write) && waitrequest) begin
      if (bus_cnt == 2'h1) begin
        waitrequest <= 1'b0;
        readdata <= rd_val;
        bus_cnt <= 2'h0;
      end else begin
        bus_cnt <= bus_cnt + 2'h1;
      end
    end else begin
      waitrequest <= 1'b1;
      bus_cnt <= 2'h0;
    end
  end

  // Software registers; settings are frozen while an operation runs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      op <= `OP_NONE;
      no_wait <= 1'b0;
      area <= 2'h0;
      wp_n <= 1'b0;
      addr <= 22'h0;
      len <= 10'h0;
      ptr <= 10'h0;
      refused <= 1'b0;
    end else begin
      if (ctrl_wr && !op_busy) begin
        no_wait <= writedata[`CTRL_NOWAIT];
        area <= writedata[`CTRL_AREA_LSB + 1:`CTRL_AREA_LSB];
        wp_n <= writedata[`CTRL_WP];
      end
      if (start) op <= new_op;
      if (go_req) refused <= refuse;
      if (do_wr && !op_busy && address[4:2] == `REG_ADDR) addr <= writedata[21:0];
      if (do_wr && !op_busy && address[4:2] == `REG_LEN)
        len <= (writedata[9:0] > `PAGE_BYTES) ? 10'd528 : writedata[9:0];
      if (do_wr && !op_busy && address[4:2] == `REG_PTR) ptr <= writedata[9:0];
      else if (host_buf && (do_wr || do_rd)) ptr <= ptr + 10'h001;
    end
  end

  // Suspend and partial-program tracking
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      suspended <= 1'b0;
      susp_blk <= 9'h0;
      last_page <= 13'h0;
      part_cnt <= 4'h0;
    end else if (start) begin
      case (new_op)
        `OP_PROG: begin
          last_page <= addr[21:9];
          part_cnt <= (addr[21:9] == last_page) ? part_cnt + 4'h1 : 4'h1;
        end
        `OP_ERASE: begin
          susp_blk <= addr[21:13];
          if (addr[21:13] == last_page[12:4]) part_cnt <= 4'h0;
        end
        `OP_RESUME: suspended <= 1'b0;
        `OP_RESET: suspended <= 1'b0;
        default: suspended <= suspended;
      endcase
    end else if (cap && (stat_rd || op == `OP_STATUS)) begin
      suspended <= io_s[`ST_SUSP];
    end
  end

  // Read results: status byte and identification codes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status_byte <= `STATUS_RST;
      maker_id <= 8'h0;
      dev_id <= 8'h0;
    end else if (cap) begin
      if (stat_rd || op == `OP_STATUS) status_byte <= io_s;
      else if (op == `OP_ID && cnt == 10'h0) maker_id <= io_s;
      else if (op == `OP_ID) dev_id <= io_s;
    end
  end

  // Sequencer: one byte per strobe, phase counted by ph
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      ph <= 4'h0;
      cnt <= 10'h0;
      stat_rd <= 1'b0;
      ce_n <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      output_strobe_n <= 1'b1;
      io_out <= 8'h0;
      io_oe_n <= 1'b1;
    end else begin
      // Write strobe: data on ph 1, WE low ph 2..3, rising at ph 4
      if (wr_state) begin
        if (ph == 4'h1) begin
          io_out <= wbyte;
          io_oe_n <= 1'b0;
          cle <= (state != S_ADDR) && (state != S_WDATA);
          ale <= (state == S_ADDR);
        end
        if (ph == 4'h2) we_n <= 1'b0;
        if (ph == `WR_RISE) we_n <= 1'b1;
        ph <= wr_last ? 4'h0 : ph + 4'h1;
      end
      // Read strobe: bus released, output strobe low until sample taken
      if (state == S_RDATA) begin
        if (ph == 4'h0) begin
          io_oe_n <= 1'b1;
          cle <= 1'b0;
          ale <= 1'b0;
        end
        if (ph == 4'h1) output_strobe_n <= 1'b0;
        if (ph == `RD_SAMPLE) output_strobe_n <= 1'b1;
        ph <= rd_last ? 4'h0 : ph + 4'h1;
      end
      case (state)
        S_IDLE: begin
          if (start) begin
            state <= S_CMD1;
            ce_n <= 1'b0;
            ph <= 4'h0;
            cnt <= 10'h0;
            stat_rd <= 1'b0;
          end
        end
        S_CMD1: begin
          if (wr_last) begin
            cnt <= 10'h0;
            if (n_addr(op) != 2'd0) state <= S_ADDR;
            else if (op == `OP_STATUS) state <= S_RDATA;
            else if (op == `OP_RESUME) state <= S_END;
            else state <= S_WAIT;
          end
        end
        S_ADDR: begin
          if (wr_last) begin
            if (cnt[1:0] == n_addr(op) - 2'd1) begin
              cnt <= 10'h0;
              case (op)
                `OP_PROG: state <= S_WDATA;
                `OP_ERASE: state <= S_CMD2;
                `OP_READ: state <= S_WAIT;
                default: state <= S_RDATA;
              endcase
            end else begin
              cnt <= cnt + 10'h1;
            end
          end
        end
        S_WDATA: begin
          if (wr_last) begin
            if (cnt == len - 10'h1) begin
              cnt <= 10'h0;
              state <= S_CMD2;
            end else begin
              cnt <= cnt + 10'h1;
            end
          end
        end
        S_CMD2: begin
          if (wr_last) state <= no_wait ? S_END : S_WAIT;
        end
        S_WAIT: begin
          // Hold off past the busy onset, then wait for ready; no timeout
          if (ph != `WB_CYC) ph <= ph + 4'h1;
          else if (rb_s) begin
            ph <= 4'h0;
            if (op == `OP_READ) state <= S_RDATA;
            else if (op == `OP_RESET) state <= S_END;
            else state <= S_SCMD;
          end
        end
        S_SCMD: begin
          if (wr_last) begin
            stat_rd <= 1'b1;
            state <= S_RDATA;
          end
        end
        S_RDATA: begin
          if (rd_last) begin
            if (cnt == nread - 10'h1) state <= S_END;
            else cnt <= cnt + 10'h1;
          end
        end
        S_END: begin
          ce_n <= 1'b1;
          io_oe_n <= 1'b1;
          cle <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// file: nand_host_ctrl_props.sv
// Checker for the host controller bus handshake and flash pin sequencing
`timescale 1ns/1ps
module nand_host_ctrl_props (
  input logic clk,
  input logic rst,
  input logic read,
  input logic write,
  input logic waitrequest,
  input logic ce_n,
  input logic cle,
  input logic ale,
  input logic we_n,
  input logic output_strobe_n,
  input logic wp_n,
  input logic [7:0] io_out,
  input logic io_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  bus_answer_a: assert property (($rose(read) || $rose(write)) |-> waitrequest ##2 !waitrequest)
    else $error("bus answer late");
  wait_single_a: assert property (!waitrequest |=> waitrequest) else $error("answer too long");
  reset_pins_a: assert property ($fell(rst) |-> ce_n && we_n && !wp_n && io_oe_n)
    else $error("pins not idle after reset");
  latch_excl_a: assert property (!(cle && ale)) else $error("both latches high");
  we_frame_a: assert property (!we_n |-> !ce_n && !io_oe_n && output_strobe_n)
    else $error("write strobe outside frame");
  we_hold_a: assert property (!we_n |=> $stable(io_out) && $stable(cle) && $stable(ale))
    else $error("byte changed under strobe");
  we_width_a: assert property ($fell(we_n) |=> !we_n ##1 we_n)
    else $error("write strobe width");
  rd_width_a: assert property (
    $fell(output_strobe_n) |-> !output_strobe_n[*6] ##1 output_strobe_n)
    else $error("read strobe width");
  rd_release_a: assert property (!output_strobe_n |-> io_oe_n && !ce_n && !cle && !ale)
    else $error("bus driven while reading");
  // Main flows reached: program, suspend, reset
  cover property (cle && !we_n && io_out == 8'h10);
  cover property (cle && !we_n && io_out == 8'hb0);
  cover property (cle && !we_n && io_out == 8'hff);
endmodule
bind nand_host_ctrl nand_host_ctrl_props nand_host_ctrl_props_i (.clk(clk), .rst(rst),
  .read(read), .write(write), .waitrequest(waitrequest), .ce_n(ce_n), .cle(cle), .ale(ale),
  .we_n(we_n), .output_strobe_n(output_strobe_n), .wp_n(wp_n), .io_out(io_out),
  .io_oe_n(io_oe_n));

// file: nand_host_defines.vh
// Constants for the NAND flash host controller: register map, codes, timing
//Behaviour
//- Program sends 80h, three address bytes, then the loaded data bytes.
//- Between one and 528 bytes may be loaded; fewer bytes are allowed.
//- At most ten partial programs of one page between erases; only the last programmed page is counted.
//- While busy only status read, suspend and reset are issued.
//- Status mode persists; a read command precedes any further page read.
//- Erase sends 60h and two block address bytes; page bits ignored.
//- ID command 90h, address 00h, then maker and device codes read.
//- Write protect is held asserted from reset until software releases it.
`ifndef NAND_HOST_DEFINES_VH
`define NAND_HOST_DEFINES_VH
// Register word offsets (address bits 4:2)
`define REG_CTRL 3'h0
`define REG_ADDR 3'h1
`define REG_LEN 3'h2
`define REG_STAT 3'h3
`define REG_ID 3'h4
`define REG_PTR 3'h5
`define REG_DATA 3'h6
// Control field positions
`define CTRL_OP_LSB 0
`define CTRL_NOWAIT 4
`define CTRL_AREA_LSB 5
`define CTRL_WP 8
// Host operations
`define OP_NONE 4'h0
`define OP_READ 4'h1
`define OP_PROG 4'h2
`define OP_ERASE 4'h3
`define OP_SUSP 4'h4
`define OP_RESUME 4'h5
`define OP_STATUS 4'h6
`define OP_ID 4'h7
`define OP_RESET 4'h8
// Device command bytes
`define CMD_READ_A 8'h00
`define CMD_READ_B 8'h01
`define CMD_READ_C 8'h50
`define CMD_LOAD 8'h80
`define CMD_PROG 8'h10
`define CMD_ERASE 8'h60
`define CMD_CONFIRM 8'hd0
`define CMD_SUSP 8'hb0
`define CMD_STATUS 8'h70
`define CMD_ID 8'h90
`define CMD_RESET 8'hff
// Status byte bits and reset value
`define ST_FAIL 0
`define ST_SUSP 5
`define ST_READY 6
`define ST_NWP 7
`define STATUS_RST 8'hc0
// Page and limits
`define PAGE_BYTES 528
`define MAX_PARTIAL 4'ha
// Timing at 40 MHz
`define CLK_MHZ 40
`define T_WB_NS 100
`define WB_CYC ((`T_WB_NS * `CLK_MHZ + 999) / 1000 + 3)
`define WR_RISE 4'h4
`define WR_LAST 4'h5
`define RD_SAMPLE 4'h7
`define RD_LAST 4'h8
`endif

// file: page_buf.v
// Single-port page buffer with registered read data
`timescale 1ns/1ps
module page_buf (
  input wire clk,
  input wire [9:0] addr,
  input wire we,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:527];
  // Read-before-write; contents are undefined until loaded
  always @(posedge clk) begin
    if (we) mem[addr] <= wdata;
    rdata <= mem[addr];
  end
endmodule

// file: pin_sync.v
// Three-stage synchroniser for the flash pins, change accepted when stages agree
`timescale 1ns/1ps
module pin_sync (
  input wire clk,
  input wire rst,
  input wire [8:0] d,
  output reg [8:0] q
);
  reg [8:0] s1;
  reg [8:0] s2;
  reg [8:0] s3;
  genvar i;
  generate
    for (i = 0; i < 9; i = i + 1) begin : g_bit
      // Stage one feeds stage two only; q moves when two and three agree
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          s1[i] <= d[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) q[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule

// file: test_nand_program_erase_command_unit.sv
// Bench: host controller over Avalon-MM against the flash model
`timescale 1ns/1ps
`include "nand_host_defines.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t got %h want %h", $time, g, e); end end
module test_nand_program_erase_command_unit;
  localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
  localparam logic [7:0] DEVICE = 8'hc3; // Arbitrary value
  logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, fail_inj = 1'b0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest, ce_n, cle, ale, we_n, output_strobe_n, wp_n, io_oe_n, ready_busy_in;
  logic [7:0] io_out, io_in;
  logic [7:0] ref_q [$];
  logic [21:0] pa;
  int error_cnt = 0, tests_run = 0, n;
  bit [31:0] seed = 58;
  nand_host_ctrl nand_host_ctrl_i (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .output_strobe_n(output_strobe_n),
    .wp_n(wp_n), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
    .ready_busy_in(ready_busy_in));
  flash_dev_model #(.MAKER(MAKER), .DEVICE(DEVICE)) flash_dev_model_i (.clk(clk),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .output_strobe_n(output_strobe_n),
    .wp_n(wp_n), .io_out(io_out), .io_oe_n(io_oe_n), .fail_next(fail_inj), .io_in(io_in),
    .ready_busy(ready_busy_in));
  initial forever #12.5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected status byte: fail, suspend, ready, not protected
  function automatic logic [7:0] st(input bit wp, input bit sp, input bit fl);
    return {wp, 1'b1, sp, 4'h0, fl};
  endfunction
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input bit wr, input [2:0] r, input [31:0] d);
    int k;
    k = 0;
    address <= {r, 2'b00};
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    q = readdata;
    `CHK(waitrequest, 1'b0)
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  // Start an operation and poll until idle; m holds area in [2:1], no-wait in [0]
  task automatic op(input [3:0] o, input bit [2:0] m, input bit wp);
    int k;
    k = 0;
    bus(1, `REG_CTRL, {23'h0, wp, 1'b0, m, o});
    do begin
      bus(0, `REG_STAT, 32'h0);
      k++;
    end while (q[8] !== 1'b0 && k < 500);
    `CHK(q[8], 1'b0)
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(25ns * 60000);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    bus(1, `REG_STAT, 32'hff);
    bus(0, `REG_STAT, 32'h0);
    `CHK(q[7:0], 8'hc0)
    bus(0, 3'h7, 32'h0);
    `CHK(q, 32'h0)
    fin("reset");
    op(`OP_STATUS, 0, 0);
    `CHK(q[7:0], st(0, 0, 0))
    fin("status");
    // Random page, column and length; short enough to stay in the first half
    n = 1 + rnd() % 24;
    pa = {13'(rnd()), 1'b0, 8'(rnd() % 200)};
    bus(1, `REG_PTR, 32'h0);
    repeat (n) begin
      ref_q.push_back(8'(rnd()));
      bus(1, `REG_DATA, {24'h0, ref_q[$]});
    end
    bus(1, `REG_LEN, n);
    bus(1, `REG_ADDR, {10'h0, pa});
    op(`OP_PROG, 0, 1);
    `CHK(q[9:0], {2'b00, st(1, 0, 0)})
    op(`OP_READ, 0, 1);
    bus(1, `REG_PTR, 32'h0);
    foreach (ref_q[i]) begin
      bus(0, `REG_DATA, 32'h0);
      `CHK(q[7:0], ref_q[i])
    end
    // Same columns through the second-half pointer find erased bytes
    op(`OP_READ, 3'b010, 1);
    bus(1, `REG_PTR, 32'h0);
    foreach (ref_q[i]) begin
      bus(0, `REG_DATA, 32'h0);
      `CHK(q[7:0], 8'hff)
    end
    fin("program");
    bus(1, `REG_LEN, 32'h0);
    op(`OP_PROG, 0, 1);
    `CHK(q[9], 1'b1)
    bus(1, `REG_LEN, 32'h1);
    for (int k = 2; k <= 11; k++) begin
      fail_inj <= (k == 5);
      op(`OP_PROG, 0, 1);
      `CHK(q[9], k == 11)
      if (k < 11) `CHK(q[0], k == 5)
    end
    `CHK(q[15:12], 4'ha)
    fin("partial");
    fail_inj <= 1'b1;
    op(`OP_ERASE, 0, 1);
    `CHK(q[7:0], st(1, 0, 1))
    `CHK(q[15:12], 4'h0)
    fail_inj <= 1'b0;
    fin("erase");
    op(`OP_ERASE, 1, 1);
    op(`OP_SUSP, 0, 1);
    `CHK(q[10:0], {1'b1, 2'b00, st(1, 1, 0)})
    op(`OP_PROG, 0, 1);
    `CHK(q[9], 1'b1)
    op(`OP_RESUME, 0, 1);
    op(`OP_STATUS, 0, 1);
    `CHK(q[10:0], {3'b000, 8'h80})
    n = 0;
    do begin
      op(`OP_STATUS, 0, 1);
      n++;
    end while (q[6] !== 1'b1 && n < 50);
    `CHK(q[7:0], st(1, 0, 0))
    fin("suspend");
    op(`OP_ID, 0, 1);
    bus(0, `REG_ID, 32'h0);
    `CHK(q[15:0], {DEVICE, MAKER})
    fin("id");
    op(`OP_RESET, 0, 1);
    op(`OP_STATUS, 0, 1);
    `CHK(q[7:0], 8'hc0)
    fin("reset command");
    test_done();
  end
endmodule
